// ---- tb/safety_sensor_diag_bytes_tb.sv ----
/*
  Bench for ssd_core: pins driven here, bus through the gateway model.
  Assumes ssd_gw and the bound checker; WARN_CYCLES shortened to 200.
*/
module safety_sensor_diag_bytes_tb
  import ssd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, hsel, hwrite, hready, hresp, out_a, out_b, dvalid;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  rsp, flt;
  ssd_pins_t   pins;
  int          mismatches, samples_checked, seed = 69;
  bit          err, won;
  logic [10:0] tab [12] = '{11'h001, 11'h601, 11'h701, 11'h781, 11'h705, 11'h709, 11'h711, 11'h721,
                            11'h703, 11'h701, 11'h601, 11'h741};
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  ssd_core #(.WARN_CYCLES(64'd200)) ssd_core_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .pins(pins), .safety_output_a(out_a), .safety_output_b(out_b),
    .response_byte(rsp), .fault_byte(flt), .fault_detail_valid(dvalid));
  ssd_gw ssd_gw_i (.mclk(mclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ==========================================================
  // Compare, report, model
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(input logic [10:0] v, input int n);
    logic       act, w;
    logic [7:0] r, f;
    pins <= v;
    repeat (n) @(posedge mclk);
    act = v[8] & !v[6];
    w = |v[5:2];
    err = v[6] | v[1] | (err & v[8]);
    if (v[0])
      won = v[10] & v[9] & act & !err;
    r = {err, w, v[7] & act & won, v[10] & v[9], 2'b00, act, won};
    f = (w | err) ? {!v[0], 1'b0, v[1], v[6], v[2], v[3], v[4], v[5]} : {!v[0], 7'h00};
    chk(32'(rsp), 32'(r));
    chk(32'(flt), 32'(f));
    chk(32'({out_a, out_b, dvalid}), 32'({won, won, w | err}));
    chk(32'({hresp, hready}), 32'h1);
    ssd_gw_i.xfer(1'b0, 32'h4, 32'h0, q);
    chk(q, 32'(r));
    ssd_gw_i.xfer(1'b0, 32'h8, 32'h0, q);
    chk(q, 32'(f));
  endtask
  initial begin
    rst = 1'b1;
    pins = 11'h001;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    foreach (tab[i]) step(tab[i], 8);
    repeat (30) step(11'($random(seed)) & 11'h7C0 | 11'h001, 8);
    step(11'h701, 8);
    step(11'h300, 8);
    step(11'h701, 8);
    err = 1'b1;
    step(11'h705, 230);
    step(11'h701, 8);
    ssd_gw_i.xfer(1'b1, 32'h0, 32'h80, q);
    ssd_gw_i.xfer(1'b0, 32'h0, 32'h0, q);
    chk(q, 32'h80);
    ssd_gw_i.xfer(1'b1, 32'h4, 32'hFF, q);
    ssd_gw_i.xfer(1'b1, 32'h0, 32'h0, q);
    err = 1'b0;
    step(11'h701, 8);
    ssd_gw_i.xfer(1'b0, 32'hC, 32'h0, q);
    chk(q, 32'h701);
    ssd_gw_i.xfer(1'b0, 32'h10, 32'h0, q);
    chk(q, 32'h0);
    end_sim();
  end
endmodule

// ---- tb/ssd_chk_sva.sv ----
/*
  Port checker for ssd_core.
  Assumes a bind to ssd_core; a pin change reaches the outputs three edges later.
*/
module ssd_chk
  import ssd_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire ssd_pins_t  pins,
  input wire logic       safety_output_a,
  input wire logic       safety_output_b,
  input wire logic [7:0] response_byte,
  input wire logic [7:0] fault_byte,
  input wire logic       fault_detail_valid
);
  // ==========================================================
  // Cycles since reset release, saturating
  logic [2:0] age;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  always_ff @(posedge mclk) begin
    if (rst)
      age <= 3'h0;
    else if (age != 3'h7)
      age <= age + 3'h1;
  end
  a_detail_valid: assert property ((response_byte[6] || response_byte[7]) |-> fault_detail_valid)
    else $error("detail flag missing");
  a_detail_quiet: assert property (!(response_byte[6] || response_byte[7]) |-> fault_byte[6:0] == 7'h00)
    else $error("fault bits without cause");
  a_inputs_live: assert property (age > 3'h3 |->
    response_byte[4] == $past(pins.safety_input_a && pins.safety_input_b, 3))
    else $error("inputs live bit wrong");
  a_actuated_bit: assert property (age > 3'h3 |->
    response_byte[1] == $past(pins.actuator_present && !pins.actuator_bad, 3))
    else $error("actuated bit wrong");
  a_guard_clear: assert property ((!pins.actuator_present && !pins.actuator_bad && !pins.internal_fault &&
    !(pins.out_fault_a || pins.out_fault_b || pins.cross_wire || pins.over_temp)) [*5] |-> !response_byte[7])
    else $error("error kept with guard open");
  a_enable_bit: assert property (response_byte[0] == safety_output_a)
    else $error("enable bit differs from output");
  a_output_pair: assert property (safety_output_a == safety_output_b)
    else $error("outputs differ");
  a_limit_on: assert property (response_byte[5] |-> response_byte[0] && response_byte[1])
    else $error("limit bit without enable");
  a_error_off: assert property (pins.link_ok [*5] ##0 response_byte[7] |-> !safety_output_a)
    else $error("error with outputs on");
  a_warn_cross: assert property (pins.cross_wire [*5] |-> response_byte[6])
    else $error("warning bit missing");
  a_link_hold: assert property ((!pins.link_ok) [*5] |=> $stable(safety_output_a))
    else $error("outputs moved on link loss");
  a_link_flag: assert property ((!pins.link_ok) [*5] |-> fault_byte[7])
    else $error("link loss flag missing");
  a_temp_flag: assert property (pins.over_temp [*5] |-> fault_byte[3])
    else $error("temperature flag missing");
endmodule

bind ssd_core ssd_chk ssd_chk_i (.mclk(mclk), .rst(rst), .pins(pins), .safety_output_a(safety_output_a),
  .safety_output_b(safety_output_b), .response_byte(response_byte), .fault_byte(fault_byte),
  .fault_detail_valid(fault_detail_valid));

// ---- tb/ssd_gw.sv ----
/*
  Gateway partner: AHB-Lite master for single word transfers.
  Assumes one slave whose hreadyout is hready; the bench calls xfer.
*/
module ssd_gw (
  input  wire logic        mclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b0, 32'h0, 2'h0, 1'b0, 3'h2, 32'h0};
  // ==========================================================
  // Bounded wait for hready
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!hready && n < 20);
    if (!hready) begin
      safety_sensor_diag_bytes_tb.mismatches++;
      safety_sensor_diag_bytes_tb.end_sim();
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

// ---- verilog/ssd_core.sv ----
/*
  Safety sensor diagnostic core: builds the response byte and the
  warning/error byte from the sensor state, latches errors, drives the
  two safety outputs and exposes request/response/fault over AHB-Lite.
  Assumes a single AHB-Lite master, word transfers, and asynchronous
  sensor pins that are synchronised here before use.
*/
// Function
// RQ1 - Whenever a warning or error is flagged, a detailed fault byte is presented for reading.
// RQ2 - The gateway sends the request byte to the sensor, and it only ever flows toward the sensor; the core also returns it on reads at 12'h000.
// RQ3 - Response and warning/error bytes only flow from the sensor toward the gateway.
// RQ4 - Every status, warning and error flag is active high, one meaning present.
// RQ5 - Response bit 4 is set exactly when both safety inputs are live.
// RQ6 - Response bit 5 is set while actuated in the limit area with the outputs still enabled.
// RQ7 - The fault byte carries a flag for loss of communication with the gateway.
// RQ8 - Response bit 0 shows outputs enabled and bit 1 shows actuated with actuator identified.
// RQ9 - Response bit 6 shows a warning with delayed switch-off and bit 7 an error with outputs off.
// RQ10 - A latched error clears once its cause is gone and request bit 7 falls or the guard opens.
// RQ11 - On communication failure the safety outputs keep their present state.
// RQ12 - Fault bits 0 to 3 report output A fault, output B fault, cross-wire and over-temperature.
`include "ssd_params.svh"

module ssd_core
  import ssd_pkg::*;
#(
  parameter longint unsigned WARN_CYCLES =
    longint'(`SSD_WARN_TIMEOUT_MIN) * 64'd60 * 64'd1000000000 / 64'(`SSD_MCLK_PERIOD_NS)
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire ssd_pins_t   pins,
  output logic             safety_output_a,
  output logic             safety_output_b,
  output logic      [7:0]  response_byte,
  output logic      [7:0]  fault_byte,
  output logic             fault_detail_valid
);

  // ==========================================================
  // Synchronised sensor pins
  ssd_pins_t p;

  ssd_sync u_sync (
    .mclk       (mclk),
    .rst        (rst),
    .pins_async (pins),
    .pins_sync  (p)
  );

  // ==========================================================
  // State
  ssd_state_t s_reg;
  ssd_state_t s_next;

  localparam logic [`SSD_WARN_CNT_W-1:0] WARN_LIMIT = WARN_CYCLES[`SSD_WARN_CNT_W-1:0];

  logic                   addr_phase;
  logic                   inputs_live;
  logic                   actuated;
  logic                   guard_open;
  logic                   comm_fail;
  logic                   warn_cause;
  logic                   warn_timeout;
  logic                   err_cause;
  logic                   req_reset_fall;
  logic                   out_target;
  logic [7:0]             detail;
  logic [`SSD_ADDR_W-1:0] rd_addr;

  // ==========================================================
  // Next state
  always_comb begin
    s_next    = s_reg;
    s_next.hreadyout = 1'b1;
    s_next.hresp     = 1'b0;

    // Bus address phase capture
    addr_phase      = hsel & htrans[1] & hready;
    rd_addr         = haddr[`SSD_ADDR_W-1:0];
    s_next.dp_valid = addr_phase;
    s_next.dp_write = addr_phase & hwrite;
    s_next.dp_addr  = addr_phase ? rd_addr : s_reg.dp_addr;

    // RQ2 request byte inbound
    if (s_reg.dp_valid && s_reg.dp_write && s_reg.dp_addr == `SSD_ADDR_REQUEST) begin
      s_next.request = hwdata[7:0];
    end
    s_next.req_reset_prev = s_reg.request[`SSD_REQ_ERR_RESET];
    req_reset_fall        = s_reg.req_reset_prev & ~s_reg.request[`SSD_REQ_ERR_RESET];

    // Sensor conditions
    inputs_live = p.safety_input_a & p.safety_input_b;
    actuated    = p.actuator_present & ~p.actuator_bad;
    guard_open  = ~p.actuator_present;
    comm_fail   = ~p.link_ok;
    warn_cause  = p.out_fault_a | p.out_fault_b | p.cross_wire | p.over_temp;

    // RQ9 delayed switch-off timer
    if (!warn_cause) begin
      s_next.warn_count = '0;
    end else if (s_reg.warn_count < WARN_LIMIT) begin
      s_next.warn_count = s_reg.warn_count + `SSD_WARN_CNT_W'(1);
    end
    warn_timeout = warn_cause & (s_reg.warn_count >= WARN_LIMIT);
    err_cause    = p.internal_fault | p.actuator_bad | warn_timeout;

    // RQ10 latch and release
    if (err_cause) begin
      s_next.err_latch = 1'b1;
    end else if (s_reg.err_latch && (req_reset_fall || guard_open)) begin
      s_next.err_latch = 1'b0;
    end

    // RQ11 hold outputs on link loss
    out_target = inputs_live & actuated & ~s_next.err_latch & ~err_cause;
    if (comm_fail) begin
      s_next.outputs_on = s_reg.outputs_on;
    end else begin
      s_next.outputs_on = out_target;
    end

    // RQ4 active high flags throughout
    s_next.diag.response = 8'h00;
    // RQ8 outputs and actuation
    s_next.diag.response[`SSD_RSP_OUT_EN]      = s_next.outputs_on;
    s_next.diag.response[`SSD_RSP_ACTUATED]    = actuated;
    // RQ5 both inputs live
    s_next.diag.response[`SSD_RSP_INPUTS_LIVE] = inputs_live;
    // RQ6 limit area flag
    s_next.diag.response[`SSD_RSP_LIMIT]       = actuated & p.actuator_limit & s_next.outputs_on;
    // RQ9 warning and error
    s_next.diag.response[`SSD_RSP_WARNING]     = warn_cause;
    s_next.diag.response[`SSD_RSP_ERROR]       = s_next.err_latch;

    // RQ12 fault detail layout
    detail = 8'h00;
    detail[`SSD_FLT_OUT_A]    = p.out_fault_a;
    detail[`SSD_FLT_OUT_B]    = p.out_fault_b;
    detail[`SSD_FLT_CROSS]    = p.cross_wire;
    detail[`SSD_FLT_TEMP]     = p.over_temp;
    detail[`SSD_FLT_ACTUATOR] = p.actuator_bad;
    detail[`SSD_FLT_INTERNAL] = p.internal_fault;
    // RQ7 link loss flag
    detail[`SSD_FLT_COMM]     = comm_fail;

    // RQ1 detail on warning or error
    s_next.detail_valid = warn_cause | s_next.err_latch;
    if (s_next.detail_valid) begin
      s_next.diag.fault = detail;
    end else begin
      s_next.diag.fault = 8'h00;
      s_next.diag.fault[`SSD_FLT_COMM] = comm_fail;
    end

    // Read data, request forwarded from a write in flight
    s_next.hrdata = 32'h0000_0000;
    if (addr_phase && !hwrite) begin
      unique case (rd_addr)
        `SSD_ADDR_REQUEST:  s_next.hrdata = {24'h00_0000, s_next.request};
        // RQ3 outbound bytes read only
        `SSD_ADDR_RESPONSE: s_next.hrdata = {24'h00_0000, s_reg.diag.response};
        `SSD_ADDR_FAULT:    s_next.hrdata = {24'h00_0000, s_reg.diag.fault};
        `SSD_ADDR_PINS:     s_next.hrdata = {21'h0, p};
        default:            s_next.hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg           <= '0;
      s_reg.request   <= `SSD_REQUEST_RESET;
      s_reg.hreadyout <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign hrdata             = s_reg.hrdata;
  assign hreadyout          = s_reg.hreadyout;
  assign hresp              = s_reg.hresp;
  assign safety_output_a    = s_reg.outputs_on;
  assign safety_output_b    = s_reg.outputs_on;
  assign response_byte      = s_reg.diag.response;
  assign fault_byte         = s_reg.diag.fault;
  assign fault_detail_valid = s_reg.detail_valid;

endmodule

// ---- verilog/ssd_params.svh ----
/*
  Constants of the safety sensor diagnostic block: register offsets,
  field positions, reset values and timing figures.
  Assumes inclusion by ssd_pkg and the top module; definitions only.
*/
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses inside the slave window)
`define SSD_ADDR_W              12
`define SSD_ADDR_REQUEST        12'h000
`define SSD_ADDR_RESPONSE       12'h004
`define SSD_ADDR_FAULT          12'h008
`define SSD_ADDR_PINS           12'h00C
`define SSD_REQUEST_RESET       8'h00

// ==========================================================
// Request byte fields
`define SSD_REQ_ERR_RESET       7

// ==========================================================
// Response byte fields
`define SSD_RSP_OUT_EN          0
`define SSD_RSP_ACTUATED        1
`define SSD_RSP_INPUTS_LIVE     4
`define SSD_RSP_LIMIT           5
`define SSD_RSP_WARNING         6
`define SSD_RSP_ERROR           7

// ==========================================================
// Fault byte fields
`define SSD_FLT_OUT_A           0
`define SSD_FLT_OUT_B           1
`define SSD_FLT_CROSS           2
`define SSD_FLT_TEMP            3
`define SSD_FLT_ACTUATOR        4
`define SSD_FLT_INTERNAL        5
`define SSD_FLT_COMM            7

// ==========================================================
// Timing
`define SSD_MCLK_PERIOD_NS      4
`define SSD_WARN_TIMEOUT_MIN    30
`define SSD_WARN_CNT_W          40

`endif

// ---- verilog/ssd_pkg.sv ----
/*
  Types of the safety sensor diagnostic block: pin bundle, diagnostic
  byte pair and the state records of both modules.
  Assumes ssd_params.svh is on the include path.
*/
`include "ssd_params.svh"

package ssd_pkg;

  // ==========================================================
  // Pin bundle from the sensor front end
  typedef struct packed {
    logic safety_input_a;
    logic safety_input_b;
    logic actuator_present;
    logic actuator_limit;
    logic actuator_bad;
    logic out_fault_a;
    logic out_fault_b;
    logic cross_wire;
    logic over_temp;
    logic internal_fault;
    logic link_ok;
  } ssd_pins_t;

  // ==========================================================
  // Outgoing diagnostic bytes
  typedef struct packed {
    logic [7:0] response;
    logic [7:0] fault;
  } ssd_diag_t;

  // ==========================================================
  // Synchroniser state
  typedef struct packed {
    ssd_pins_t stage1;
    ssd_pins_t stage2;
  } ssd_sync_state_t;

  // ==========================================================
  // Top state
  typedef struct packed {
    logic                          dp_valid;
    logic                          dp_write;
    logic [`SSD_ADDR_W-1:0]        dp_addr;
    logic [31:0]                   hrdata;
    logic                          hreadyout;
    logic                          hresp;
    logic [7:0]                    request;
    logic                          req_reset_prev;
    logic                          err_latch;
    logic [`SSD_WARN_CNT_W-1:0]    warn_count;
    logic                          outputs_on;
    ssd_diag_t                     diag;
    logic                          detail_valid;
  } ssd_state_t;

endpackage

// ---- verilog/ssd_sync.sv ----
/*
  Two-stage synchroniser for the sensor pin bundle.
  Assumes pins change asynchronously to mclk; rst is synchronous.
*/
module ssd_sync
  import ssd_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire ssd_pins_t pins_async,
  output ssd_pins_t      pins_sync
);

  ssd_sync_state_t s_reg;
  ssd_sync_state_t s_next;

  always_comb begin
    s_next        = s_reg;
    s_next.stage1 = pins_async;
    s_next.stage2 = s_reg.stage1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins_sync = s_reg.stage2;

endmodule
